// ### ffe_defines.svh
// Offsets, field positions, reset values and frame constants of the frame format engine.
`ifndef FFE_DEFINES_SVH
`define FFE_DEFINES_SVH
`define FFE_REG_CFG 4'h0
`define FFE_REG_MAXLEN 4'h4
`define FFE_REG_IFG 4'h8
`define FFE_REG_STAT 4'hc
`define FFE_CFG_CUSTOM 0
`define FFE_CFG_TXFCS 1
`define FFE_CFG_RXFCS 2
`define FFE_CFG_LENCHK 3
`define FFE_CFG_VLAN 4
`define FFE_CFG_STACK 5
`define FFE_CFG_LASTTAG 6
`define FFE_CFG_W 7
`define FFE_CFG_RST 7'h00
`define FFE_MAXLEN_RST 16'h05ee
`define FFE_IFG_BITS 96
`define FFE_BITS_PER_CLK 8
`define FFE_IFG_MIN 8'(`FFE_IFG_BITS / `FFE_BITS_PER_CLK)
`define FFE_PRE_BYTE 8'h55
`define FFE_SD_BYTE 8'hd5
`define FFE_PAD_BYTE 8'h00
`define FFE_PRE_LEN 3'h7
`define FFE_TYPE_MIN 16'h0600
`define FFE_TPID 16'h8100
`define FFE_TPID_STK 16'h88a8
`define FFE_PAUSE 16'h8808
`define FFE_VLAN_EXTRA 17'h00004
`define FFE_MIN_FRAME 16'h0040
`define FFE_MIN_NOFCS 16'h003c
`define FFE_FCS_LEN 16'h0004
`define FFE_LT_POS 16'h000c
`define FFE_TAG_LEN 16'h0004
`define FFE_CRC_POLY 32'hedb88320
`define FFE_CRC_INIT 32'hffffffff
`define FFE_CRC_RESID 32'hdebb20e3
`define FFE_RESP_OK 2'h0
`define FFE_RESP_ERR 2'h2
`endif

// ### ffe_pkg.sv
// Types shared by the frame format engine.
package ffe_pkg;
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} ffe_byte_type;
	typedef struct packed {
		logic en;
		logic [7:0] data;
	} ffe_phy_type;
	typedef struct packed {
		logic pause;
		logic len_err;
		logic bad;
	} ffe_stat_type;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_PRE = 3'h1, TX_DATA = 3'h3, TX_PAD = 3'h2, TX_FCS = 3'h6, TX_GAP = 3'h7
	} ffe_tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE = 2'h0, RX_PRE = 2'h1, RX_DATA = 2'h3, RX_DROP = 2'h2
	} ffe_rx_state_type;
endpackage

// ### ffe_top.sv
// Frame format engine: transmit framing, receive checking and an AXI4-Lite register slave.
// Contract
// RULE1: Transmit puts seven 0x55 preamble bytes ahead of every frame.
// RULE2: Receive strips the preamble unless custom preamble mode is on.
// RULE3: Transmit inserts start delimiter 0xd5; receive always removes it.
// RULE4: Custom mode: client byte replaces delimiter on transmit; receive skips its check.
// RULE5: Destination then source address lead transmit data; receive keeps both.
// RULE6: The client always supplies the source address; it passes unaltered.
// RULE7: Length/type of 1536 or more is a type, else a data byte count.
// RULE8: 0x8100 marks VLAN, 0x8808 pause; stacked mode adds 0x88a8 as VLAN.
// RULE9: With VLAN enabled, tagged frames may exceed maximum by four bytes only.
// RULE10: Transmit length/type passes through unchanged.
// RULE11: Receive uses a length value to strip trailing pad bytes.
// RULE12: With length checking on, a length mismatch is flagged.
// RULE13: A type value passes unprocessed and stays in receive data.
// RULE14: Optionally, length/type after the last VLAN tag is used.
// RULE15: Frames are padded to 64 bytes; pad counts in the check sequence.
// RULE16: Device pad implies device check field; client pad lets a bit choose. With TXFCS set, the device pads to 64 bytes and adds no check field.
// RULE17: Receive withholds pad unless check-field passing is configured.
// RULE18: CRC-32 over address, length/type, data and pad, x31 sent first.
// RULE19: Every received check field is verified; bad frames are reported.
// RULE20: A bit selects forwarding or removal of the received check field.
// RULE21: At least 96 bit times separate transmitted frames.
// RULE22: After the gap, the next frame starts on a 4-byte boundary.
// RULE23: Receive status comes with or right after the final data transfer.
`timescale 1ns/10ps
`include "ffe_defines.svh"
module ffe_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [3:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [3:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire ffe_pkg::ffe_byte_type tx_in,
	output ffe_pkg::ffe_phy_type tx_phy,
	input wire ffe_pkg::ffe_phy_type rx_phy,
	output logic rx_valid,
	output ffe_pkg::ffe_byte_type rx_out,
	output logic rx_stat_valid,
	output ffe_pkg::ffe_stat_type rx_stat
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	function automatic logic [31:0] ffe_crc8(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int k = 0; k < 8; k++) begin
			r = (r[0] ^ d[k]) ? ((r >> 1) ^ `FFE_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Register slave.
	// ------------------------------------------------------------
	logic [`FFE_CFG_W-1:0] cfg_r;
	logic [15:0] maxlen_r;
	logic [7:0] ifg_r;
	logic [15:0] rx_cnt_r, rx_bad_cnt_r;
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r, wmask;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
	wire ar_take = arvalid && arready;
	wire w_cfg = (awaddr_r == `FFE_REG_CFG);
	wire w_max = (awaddr_r == `FFE_REG_MAXLEN);
	wire w_ifg = (awaddr_r == `FFE_REG_IFG);
	wire w_map = w_cfg || w_max || w_ifg || (awaddr_r == `FFE_REG_STAT);
	wire r_map = (araddr[1:0] == 2'h0);
	wire [31:0] cfg_w = ({25'h0, cfg_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] max_w = ({16'h0, maxlen_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] ifg_w = ({24'h0, ifg_r} & ~wmask) | (wdata_r & wmask);
	wire [31:0] rd_mux = (araddr == `FFE_REG_CFG) ? {25'h0, cfg_r} :
		(araddr == `FFE_REG_MAXLEN) ? {16'h0, maxlen_r} :
		(araddr == `FFE_REG_IFG) ? {24'h0, ifg_r} :
		(araddr == `FFE_REG_STAT) ? {rx_bad_cnt_r, rx_cnt_r} : 32'h0;
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_strb
			assign wmask[8*gb +: 8] = {8{wstrb_r[gb]}};
		end
	endgenerate
	assign awready = !aw_hold_r && !bvalid_r;
	assign wready = !w_hold_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	wire custom = cfg_r[`FFE_CFG_CUSTOM];
	wire tx_inband = cfg_r[`FFE_CFG_TXFCS];
	wire rx_pass = cfg_r[`FFE_CFG_RXFCS];
	wire len_chk = cfg_r[`FFE_CFG_LENCHK];
	wire vlan_en = cfg_r[`FFE_CFG_VLAN];
	wire stack = cfg_r[`FFE_CFG_STACK];
	wire last_tag = cfg_r[`FFE_CFG_LASTTAG];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bresp_r <= `FFE_RESP_OK;
			rresp_r <= `FFE_RESP_OK;
			rdata_r <= 32'h0;
			cfg_r <= `FFE_CFG_RST;
			maxlen_r <= `FFE_MAXLEN_RST;
			ifg_r <= `FFE_IFG_MIN;
		end else begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= w_map ? `FFE_RESP_OK : `FFE_RESP_ERR;
				if (w_cfg) cfg_r <= cfg_w[`FFE_CFG_W-1:0];
				if (w_max) maxlen_r <= max_w[15:0];
				if (w_ifg) ifg_r <= ifg_w[7:0];
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= r_map ? `FFE_RESP_OK : `FFE_RESP_ERR;
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit framer.
	// ------------------------------------------------------------
	ffe_pkg::ffe_tx_state_type tx_st_r, tx_st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [7:0] gap_r, gap_nxt;
	logic [1:0] lane_r;
	logic [31:0] tcrc_r, tcrc_nxt;
	ffe_pkg::ffe_phy_type phy_r, phy_nxt;
	wire [7:0] ifg_eff = (ifg_r < `FFE_IFG_MIN) ? `FFE_IFG_MIN : ifg_r;
	wire [15:0] pad_tgt = tx_inband ? `FFE_MIN_FRAME : `FFE_MIN_NOFCS;
	wire [15:0] cnt_inc = cnt_r + 16'h1;
	wire pre_end = (cnt_r[2:0] == `FFE_PRE_LEN);
	assign tx_ready = (tx_st_r == ffe_pkg::TX_DATA) || (tx_st_r == ffe_pkg::TX_PRE && custom && pre_end);
	assign tx_phy = phy_r;

	always_comb begin
		tx_st_nxt = tx_st_r;
		cnt_nxt = cnt_r;
		gap_nxt = gap_r;
		tcrc_nxt = tcrc_r;
		phy_nxt = '0;
		case (tx_st_r)
			ffe_pkg::TX_IDLE: begin
				cnt_nxt = 16'h0;
				if (tx_valid && lane_r == 2'h3) tx_st_nxt = ffe_pkg::TX_PRE; // [RULE22]
			end
			ffe_pkg::TX_PRE: begin
				phy_nxt = {1'b1, `FFE_PRE_BYTE}; // [RULE1]
				cnt_nxt = cnt_inc;
				if (pre_end) begin
					phy_nxt.data = custom ? tx_in.data : `FFE_SD_BYTE; // [RULE3] [RULE4]
					tx_st_nxt = ffe_pkg::TX_DATA;
					cnt_nxt = 16'h0;
					tcrc_nxt = `FFE_CRC_INIT;
				end
			end
			ffe_pkg::TX_DATA: begin
				if (tx_valid) begin
					phy_nxt = {1'b1, tx_in.data}; // [RULE5] [RULE6] [RULE10]
					tcrc_nxt = ffe_crc8(tcrc_r, tx_in.data); // [RULE18]
					cnt_nxt = cnt_inc;
					gap_nxt = 8'h0;
					if (tx_in.last) begin
						if (cnt_inc < pad_tgt) tx_st_nxt = ffe_pkg::TX_PAD; // [RULE15]
						else tx_st_nxt = tx_inband ? ffe_pkg::TX_GAP : ffe_pkg::TX_FCS; // [RULE16]
					end
				end
			end
			ffe_pkg::TX_PAD: begin
				phy_nxt = {1'b1, `FFE_PAD_BYTE};
				tcrc_nxt = ffe_crc8(tcrc_r, `FFE_PAD_BYTE); // [RULE15]
				cnt_nxt = cnt_inc;
				if (cnt_inc >= pad_tgt) tx_st_nxt = tx_inband ? ffe_pkg::TX_GAP : ffe_pkg::TX_FCS; // [RULE16]
			end
			ffe_pkg::TX_FCS: begin
				phy_nxt = {1'b1, ~tcrc_r[7:0]}; // [RULE18]
				tcrc_nxt = {8'hff, tcrc_r[31:8]};
				gap_nxt = gap_r + 8'h1;
				if (gap_r == 8'h3) begin
					tx_st_nxt = ffe_pkg::TX_GAP;
					gap_nxt = 8'h0;
				end
			end
			ffe_pkg::TX_GAP: begin
				gap_nxt = gap_r + 8'h1;
				if (gap_r >= ifg_eff - 8'h1) tx_st_nxt = ffe_pkg::TX_IDLE; // [RULE21]
			end
			default: tx_st_nxt = ffe_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r <= ffe_pkg::TX_IDLE;
			cnt_r <= 16'h0;
			gap_r <= 8'h0;
			lane_r <= 2'h0;
			tcrc_r <= `FFE_CRC_INIT;
			phy_r <= '0;
		end else begin
			tx_st_r <= tx_st_nxt;
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
			lane_r <= lane_r + 2'h1;
			tcrc_r <= tcrc_nxt;
			phy_r <= phy_nxt;
		end
	end

	// ------------------------------------------------------------
	// Receive checker.
	// ------------------------------------------------------------
	ffe_pkg::ffe_rx_state_type rx_st_r, rx_st_nxt;
	logic [15:0] idx_r, idx_nxt, lt_r, lt_nxt, ltp_r, ltp_nxt;
	logic [7:0] lth_r, lth_nxt;
	logic [2:0] pre_r, pre_nxt;
	logic [4:0][7:0] sr_r, sr_nxt;
	logic [31:0] rcrc_r, rcrc_nxt;
	logic vlan_r, vlan_nxt, pause_r, pause_nxt, ltok_r, ltok_nxt;
	logic rv_nxt, rv_r, sv_nxt, sv_r;
	logic held_r, held_nxt;
	logic [7:0] hold_r, hold_nxt;
	ffe_pkg::ffe_byte_type ro_nxt, ro_r;
	ffe_pkg::ffe_stat_type st_nxt, st_r;
	wire [7:0] d = rx_phy.data;
	wire [15:0] tap = rx_pass ? 16'h0 : 16'h4; // [RULE20]
	wire [15:0] j = idx_r - 16'h1 - tap;
	wire [15:0] lt_val = {lth_r, d};
	wire is_tag = (lt_val == `FFE_TPID) || (stack && lt_val == `FFE_TPID_STK); // [RULE8]
	wire is_len = ltok_r && (lt_r < `FFE_TYPE_MIN); // [RULE7] [RULE13]
	wire [16:0] keep = (is_len && !rx_pass) ? {1'b0, ltp_r} + 17'h2 + {1'b0, lt_r} : 17'h1ffff; // [RULE11] [RULE17]
	wire keep_j = {1'b0, j} < keep;
	wire last_j = ({1'b0, j} + 17'h1) == keep;
	wire [15:0] nofcs = idx_r - `FFE_FCS_LEN;
	wire [15:0] dlen = nofcs - ltp_r - 16'h2;
	wire [16:0] max_lim = {1'b0, maxlen_r} + ((vlan_r && vlan_en) ? `FFE_VLAN_EXTRA : 17'h0); // [RULE9]
	wire len_bad = len_chk && is_len && ((lt_r > dlen) || (lt_r < dlen && nofcs > `FFE_MIN_NOFCS)); // [RULE12]
	wire crc_bad = (rcrc_r != `FFE_CRC_RESID);
	wire size_bad = (idx_r < `FFE_MIN_FRAME) || ({1'b0, idx_r} > max_lim);
	assign rx_valid = rv_r;
	assign rx_out = ro_r;
	assign rx_stat_valid = sv_r;
	assign rx_stat = st_r;

	always_comb begin
		rx_st_nxt = rx_st_r;
		idx_nxt = idx_r;
		lt_nxt = lt_r;
		ltp_nxt = ltp_r;
		lth_nxt = lth_r;
		pre_nxt = pre_r;
		sr_nxt = sr_r;
		rcrc_nxt = rcrc_r;
		vlan_nxt = vlan_r;
		pause_nxt = pause_r;
		ltok_nxt = ltok_r;
		held_nxt = held_r;
		hold_nxt = hold_r;
		rv_nxt = 1'b0;
		ro_nxt = '0;
		sv_nxt = 1'b0;
		st_nxt = st_r;
		case (rx_st_r)
			ffe_pkg::RX_IDLE: begin
				if (rx_phy.en) begin
					pre_nxt = 3'h1;
					rx_st_nxt = (custom || d == `FFE_PRE_BYTE) ? ffe_pkg::RX_PRE : ffe_pkg::RX_DROP;
					rv_nxt = custom; // [RULE2]
					ro_nxt = {1'b0, d};
				end
			end
			ffe_pkg::RX_PRE: begin
				idx_nxt = 16'h0;
				ltp_nxt = `FFE_LT_POS;
				ltok_nxt = 1'b0;
				vlan_nxt = 1'b0;
				pause_nxt = 1'b0;
				rcrc_nxt = `FFE_CRC_INIT;
				held_nxt = 1'b0;
				if (!rx_phy.en) rx_st_nxt = ffe_pkg::RX_IDLE;
				else if (custom) begin
					pre_nxt = pre_r + 3'h1;
					rv_nxt = (pre_r != `FFE_PRE_LEN); // [RULE2]
					ro_nxt = {1'b0, d};
					if (pre_r == `FFE_PRE_LEN) rx_st_nxt = ffe_pkg::RX_DATA; // [RULE4] [RULE3]
				end else if (d == `FFE_SD_BYTE) rx_st_nxt = ffe_pkg::RX_DATA; // [RULE3]
				else if (d != `FFE_PRE_BYTE) rx_st_nxt = ffe_pkg::RX_DROP;
			end
			ffe_pkg::RX_DATA: begin
				if (rx_phy.en) begin
					sr_nxt = {sr_r[3:0], d};
					rcrc_nxt = ffe_crc8(rcrc_r, d); // [RULE19]
					idx_nxt = idx_r + 16'h1;
					if (idx_r == ltp_r) lth_nxt = d;
					if (idx_r == ltp_r + 16'h1) begin
						if (ltp_r == `FFE_LT_POS) begin
							vlan_nxt = is_tag;
							pause_nxt = (lt_val == `FFE_PAUSE); // [RULE8]
						end
						if (is_tag && last_tag) ltp_nxt = ltp_r + `FFE_TAG_LEN; // [RULE14]
						else begin
							lt_nxt = lt_val;
							ltok_nxt = 1'b1;
						end
					end
					rv_nxt = (idx_r > tap) && keep_j && !last_j; // [RULE5] [RULE13]
					ro_nxt = {1'b0, sr_r[tap[2:0]]};
					// The final kept byte waits for the frame end so that it leaves with the status.
					if ((idx_r > tap) && last_j) begin
						held_nxt = 1'b1; // [RULE23]
						hold_nxt = sr_r[tap[2:0]];
					end
				end else begin
					rv_nxt = ((idx_r > tap) && keep_j) || held_r; // [RULE23]
					ro_nxt = {1'b1, held_r ? hold_r : sr_r[tap[2:0]]};
					sv_nxt = 1'b1;
					st_nxt.bad = crc_bad || size_bad || len_bad; // [RULE19]
					st_nxt.len_err = len_bad; // [RULE12]
					st_nxt.pause = pause_r;
					rx_st_nxt = ffe_pkg::RX_IDLE;
				end
			end
			ffe_pkg::RX_DROP: if (!rx_phy.en) rx_st_nxt = ffe_pkg::RX_IDLE;
			default: rx_st_nxt = ffe_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_st_r <= ffe_pkg::RX_IDLE;
			idx_r <= 16'h0;
			lt_r <= 16'h0;
			ltp_r <= `FFE_LT_POS;
			lth_r <= 8'h0;
			pre_r <= 3'h0;
			sr_r <= '0;
			rcrc_r <= `FFE_CRC_INIT;
			vlan_r <= 1'b0;
			pause_r <= 1'b0;
			ltok_r <= 1'b0;
			held_r <= 1'b0;
			hold_r <= 8'h00;
			rv_r <= 1'b0;
			ro_r <= '0;
			sv_r <= 1'b0;
			st_r <= '0;
			rx_cnt_r <= 16'h0;
			rx_bad_cnt_r <= 16'h0;
		end else begin
			rx_st_r <= rx_st_nxt;
			idx_r <= idx_nxt;
			lt_r <= lt_nxt;
			ltp_r <= ltp_nxt;
			lth_r <= lth_nxt;
			pre_r <= pre_nxt;
			sr_r <= sr_nxt;
			rcrc_r <= rcrc_nxt;
			vlan_r <= vlan_nxt;
			pause_r <= pause_nxt;
			ltok_r <= ltok_nxt;
			held_r <= held_nxt;
			hold_r <= hold_nxt;
			rv_r <= rv_nxt;
			ro_r <= ro_nxt;
			sv_r <= sv_nxt;
			st_r <= st_nxt;
			if (sv_nxt) rx_cnt_r <= rx_cnt_r + 16'h1;
			if (sv_nxt && st_nxt.bad) rx_bad_cnt_r <= rx_bad_cnt_r + 16'h1;
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	logic [15:0] run_r, idle_r;
	logic seen_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= 16'h0;
			idle_r <= 16'h0;
			seen_r <= 1'b0;
		end else begin
			run_r <= phy_r.en ? run_r + 16'h1 : 16'h0;
			idle_r <= phy_r.en ? 16'h0 : idle_r + 16'h1;
			if (phy_r.en) seen_r <= 1'b1;
		end
	end
	sequence s_fcs4;
		(tx_st_r == ffe_pkg::TX_FCS) [*4] ##1 (tx_st_r == ffe_pkg::TX_GAP);
	endsequence
	AST_PRE: assert property ((tx_st_r == ffe_pkg::TX_PRE && !pre_end) |=> phy_r == {1'b1, 8'h55}) // [RULE1]
		else $error("preamble byte wrong");
	AST_SD: assert property ((tx_st_r == ffe_pkg::TX_PRE && pre_end && !custom) |=> phy_r == {1'b1, 8'hd5}) // [RULE3]
		else $error("start delimiter wrong");
	AST_FCS_LEN: assert property ($rose(tx_st_r == ffe_pkg::TX_FCS) |-> s_fcs4) // [RULE18]
		else $error("check field not four bytes");
	AST_MIN_FRAME: assert property ($fell(phy_r.en) |-> run_r >= 16'h0048) // [RULE15]
		else $error("frame shorter than minimum");
	AST_GAP: assert property (($rose(phy_r.en) && seen_r) |-> idle_r >= 16'h000c) // [RULE21]
		else $error("interframe gap too short");
	AST_ALIGN: assert property ($rose(phy_r.en) |-> lane_r == 2'h1) // [RULE22]
		else $error("frame start not aligned");
	AST_RX_BAD: assert property ((rx_st_r == ffe_pkg::RX_DATA && !rx_phy.en && crc_bad) |=> sv_r && st_r.bad) // [RULE19]
		else $error("bad check field not reported");
	AST_SD_STRIP: assert property ((rx_st_r == ffe_pkg::RX_PRE && !custom && rx_phy.en) |=> !rv_r) // [RULE3]
		else $error("delimiter passed to client");
	AST_BRESP: assert property (do_write |=> bvalid_r [*1] ##0 !aw_hold_r)
		else $error("write not answered");
endmodule

// ### ffe_phy_model.sv
// Line-side partner of the frame format engine: records transmit bytes and plays receive frames.
`timescale 1ns/10ps
module ffe_phy_model (
	input wire logic aclk,
	input wire ffe_pkg::ffe_phy_type tx_phy,
	output ffe_pkg::ffe_phy_type rx_phy
);
	logic [7:0] txq[$];
	int tx_start[$];
	int cyc = 0;
	logic prev_en = 1'b0;
	initial rx_phy = '0;
	// ----------------------------------------
	// Transmit capture.
	// ----------------------------------------
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		prev_en <= tx_phy.en;
		if (tx_phy.en) begin
			txq.push_back(tx_phy.data);
			if (!prev_en) begin
				tx_start.push_back(cyc);
			end
		end
	end
	// ----------------------------------------
	// Receive playback.
	// ----------------------------------------
	// One byte per cycle with en high, then at least one idle cycle between frames.
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge aclk);
			rx_phy <= {1'b1, b[i]};
		end
		@(posedge aclk);
		// A released line shows the inverse of its last byte, not a held value.
		rx_phy <= {1'b0, ~rx_phy.data};
		@(posedge aclk);
	endtask
endmodule

// ### ffe_top_tb.sv
// Self-checking bench of the frame format engine.
`timescale 1ns/10ps
`include "ffe_defines.svh"
module ffe_top_tb;
	typedef logic [7:0] ffe_bq_type[$];
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic tx_valid = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	ffe_pkg::ffe_byte_type tx_in = '0;
	logic awready, wready, bvalid, arready, rvalid, tx_ready, rx_valid, rx_stat_valid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	ffe_pkg::ffe_phy_type tx_phy, rx_phy;
	ffe_pkg::ffe_byte_type rx_out;
	ffe_pkg::ffe_stat_type rx_stat;
	int bad_count = 0;
	int num_checks = 0;
	int stat_seen = 0;
	int rx_num = 0;
	int rx_bad = 0;
	int last_at = -1;
	logic stat_last = 1'b0;
	logic [15:0] inner = 16'h0;
	logic [7:0] rxq[$];
	ffe_bq_type f, exp;
	always #5 aclk = ~aclk;
	ffe_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_in(tx_in), .tx_phy(tx_phy),
		.rx_phy(rx_phy), .rx_valid(rx_valid), .rx_out(rx_out), .rx_stat_valid(rx_stat_valid), .rx_stat(rx_stat));
	ffe_phy_model u_phy (.aclk(aclk), .tx_phy(tx_phy), .rx_phy(rx_phy));
	always @(posedge aclk) begin
		if (rx_valid) begin
			if (rx_out.last) last_at = rxq.size();
			rxq.push_back(rx_out.data);
		end
		if (rx_stat_valid) begin
			stat_seen++;
			stat_last = rx_valid && rx_out.last;
		end
	end
	// ----------------------------------------
	// Reporting.
	// ----------------------------------------
	task automatic tally_and_finish();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic give_up();
		bad_count++;
		$display("wrong value at %0t: wait ran out", $time);
		tally_and_finish();
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		num_checks++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		give_up();
	end
	// ----------------------------------------
	// Bus and frame helpers.
	// ----------------------------------------
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		int n;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		if (!bvalid) give_up();
		check(32'(bresp), 32'h0, "write response");
	endtask
	task automatic axi_read(input logic [3:0] a);
		int n;
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		if (!rvalid) give_up();
		rd = rdata;
		rsp = rresp;
	endtask
	function automatic ffe_bq_type make_frame(input logic [15:0] lt, input int nd);
		ffe_bq_type q;
		for (int i = 0; i < 12; i++) q.push_back(8'h10 + 8'(i));
		q.push_back(lt[15:8]);
		q.push_back(lt[7:0]);
		for (int i = 0; i < nd; i++) q.push_back(8'ha0 + 8'(i));
		return q;
	endfunction
	// Appends the check field, reflected CRC-32 complemented, lowest byte first.
	function automatic ffe_bq_type add_fcs(input ffe_bq_type q);
		logic [31:0] c;
		c = 32'hffffffff;
		foreach (q[i]) begin
			c = c ^ {24'h0, q[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		end
		c = ~c;
		for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]);
		return q;
	endfunction
	task automatic tx_frame(input ffe_bq_type b);
		int n;
		foreach (b[i]) begin
			tx_valid <= 1'b1;
			tx_in <= {i == b.size() - 1, b[i]};
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!tx_ready && n < 200);
			if (!tx_ready) give_up();
		end
		tx_valid <= 1'b0;
		@(posedge aclk);
	endtask
	// Sends one line frame; keep below zero skips the byte compare.
	task automatic rx_case(input logic [15:0] lt, input int nd, input int keep, input logic [2:0] st,
		input logic bad_crc, input logic custom);
		ffe_bq_type g, line;
		int n;
		g = make_frame(lt, nd);
		if (inner != 16'h0) begin
			g[16] = inner[15:8];
			g[17] = inner[7:0];
		end
		g = add_fcs(g);
		for (int i = 0; i < 7; i++) line.push_back(8'h55);
		line.push_back(custom ? 8'h3c : 8'hd5);
		foreach (g[i]) line.push_back(g[i]);
		if (bad_crc) line[line.size() - 1] = line[line.size() - 1] ^ 8'h01;
		rxq.delete();
		n = stat_seen;
		rx_num++;
		last_at = -1;
		if (st[0]) rx_bad++;
		u_phy.send(line);
		for (int k = 0; k < 100 && stat_seen == n; k++) @(posedge aclk);
		if (stat_seen == n) give_up();
		check(32'(rx_stat), 32'(st), "receive status");
		check(32'(stat_last), 32'h1, "status with last byte");
		if (keep >= 0) begin
			check(rxq.size(), keep, "receive byte count");
			check(last_at, keep - 1, "last marker");
			for (int i = 0; i < keep && i < rxq.size(); i++) begin
				check(32'(rxq[i]), 32'(custom ? (i < 7 ? 8'h55 : g[i - 7]) : g[i]), "receive byte");
			end
		end
	endtask
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		int n;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(4'h0);
		check(rd, 32'h0, "config reset");
		axi_read(4'h4);
		check(rd, 32'h000005ee, "max length reset");
		axi_read(4'h8);
		check(rd, 32'h0000000c, "gap reset");
		axi_read(4'h1);
		check(32'(rsp), 32'h2, "misaligned read");
		f = make_frame(16'h0800, 2);
		tx_frame(f);
		tx_frame(f);
		n = 0;
		while ((u_phy.txq.size() < 144 || tx_phy.en) && n < 300) begin
			@(posedge aclk);
			n++;
		end
		for (int i = 0; i < 7; i++) exp.push_back(8'h55);
		exp.push_back(8'hd5);
		while (f.size() < 60) f.push_back(8'h00);
		f = add_fcs(f);
		foreach (f[i]) exp.push_back(f[i]);
		check(u_phy.txq.size(), 144, "line byte count");
		for (int i = 0; i < 144 && i < u_phy.txq.size(); i++) begin
			check(32'(u_phy.txq[i]), 32'(exp[i % 72]), "line byte");
		end
		check(u_phy.tx_start.size(), 2, "frame starts");
		if (u_phy.tx_start.size() == 2) begin
			n = u_phy.tx_start[1] - u_phy.tx_start[0];
			check(32'(n >= 84), 32'h1, "gap length");
			check(32'(n % 4), 32'h0, "start alignment");
		end
		axi_write(4'h0, 32'h00000008);
		rx_case(16'h0800, 50, 64, 3'b000, 1'b0, 1'b0);
		rx_case(16'h0800, 50, 64, 3'b001, 1'b1, 1'b0);
		rx_case(16'h0600, 50, 64, 3'b000, 1'b0, 1'b0);
		rx_case(16'h05ff, 50, -1, 3'b011, 1'b0, 1'b0);
		rx_case(16'h0002, 46, 16, 3'b000, 1'b0, 1'b0);
		rx_case(16'h0030, 50, -1, 3'b011, 1'b0, 1'b0);
		rx_case(16'h8808, 46, 60, 3'b100, 1'b0, 1'b0);
		axi_write(4'h0, 32'h0000000c);
		rx_case(16'h0002, 46, 64, 3'b000, 1'b0, 1'b0);
		axi_write(4'h4, 32'h00000044);
		axi_write(4'h0, 32'h00000018);
		rx_case(16'h8100, 54, 68, 3'b000, 1'b0, 1'b0);
		rx_case(16'h8100, 55, -1, 3'b001, 1'b0, 1'b0);
		rx_case(16'h88a8, 54, -1, 3'b001, 1'b0, 1'b0);
		axi_write(4'h0, 32'h00000038);
		rx_case(16'h88a8, 54, 68, 3'b000, 1'b0, 1'b0);
		rx_case(16'h88a8, 55, -1, 3'b001, 1'b0, 1'b0);
		axi_write(4'h0, 32'h00000058);
		inner = 16'h0002;
		rx_case(16'h8100, 46, 20, 3'b000, 1'b0, 1'b0);
		inner = 16'h0030;
		rx_case(16'h8100, 50, -1, 3'b011, 1'b0, 1'b0);
		inner = 16'h0;
		axi_write(4'h0, 32'h00000001);
		rx_case(16'h0800, 50, 71, 3'b000, 1'b0, 1'b1);
		axi_write(4'h0, 32'h00000003);
		u_phy.txq.delete();
		f = make_frame(16'h0800, 2);
		f.push_front(8'h3c);
		tx_frame(f);
		n = 0;
		while ((u_phy.txq.size() < 72 || tx_phy.en) && n < 300) begin
			@(posedge aclk);
			n++;
		end
		while (f.size() < 65) f.push_back(8'h00);
		check(u_phy.txq.size(), 72, "custom line byte count");
		for (int i = 0; i < 72 && i < u_phy.txq.size(); i++) begin
			check(32'(u_phy.txq[i]), 32'(i < 7 ? 8'h55 : f[i - 7]), "custom line byte");
		end
		axi_read(4'hc);
		check(32'(rd[15:0]), 32'(rx_num), "frame count");
		check(32'(rd[31:16]), 32'(rx_bad), "bad frame count");
		tally_and_finish();
	end
endmodule
